// [oapf_defines.svh]
// constants for the operand addressing and program counter block
// assumes inclusion by the package, the core and the bench
`ifndef OAPF_DEFINES_SVH
`define OAPF_DEFINES_SVH
`define OAPF_PC_RESET        16'h0000
`define OAPF_SPECIAL_BASE    8'h80
`define OAPF_ADDR_CTRL       12'h000
`define OAPF_ADDR_CMD        12'h004
`define OAPF_ADDR_OPER       12'h008
`define OAPF_ADDR_PTR0       12'h00c
`define OAPF_ADDR_PTR1       12'h010
`define OAPF_ADDR_ACC        12'h014
`define OAPF_ADDR_PC         12'h018
`define OAPF_ADDR_RESULT     12'h01c
`define OAPF_ADDR_STATUS     12'h020
`define OAPF_ADDR_MEMRD      12'h024
`define OAPF_ADDR_MEMWR      12'h028
`define OAPF_CTRL_CFWS_BIT   0
`define OAPF_CTRL_PSEL_BIT   1
`define OAPF_CTRL_WPROT_BIT  2
`define OAPF_CTRL_JBIT_BIT   3
`define OAPF_RESP_OKAY       2'b00
`define OAPF_RESP_SLVERR     2'b10
`define OAPF_OP_W            4
`endif

// [oapf_pkg.sv]
// types shared by the operand addressing block
// assumes oapf_defines.svh is on the include path
package oapf_pkg;
  `include "oapf_defines.svh"
  typedef enum logic [3:0] {
    OAPF_OP_NOP,
    OAPF_OP_IMM,
    OAPF_OP_DIR_RD,
    OAPF_OP_IND_RD,
    OAPF_OP_IND_WR,
    OAPF_OP_XDP_RD,
    OAPF_OP_XDP_WR,
    OAPF_OP_XRI_RD,
    OAPF_OP_XRI_WR,
    OAPF_OP_CODE_DP,
    OAPF_OP_CODE_PC,
    OAPF_OP_BIT_JMP,
    OAPF_OP_ERASE
  } oapf_op_e;
  typedef enum logic [2:0] {
    OAPF_SP_IRAM,
    OAPF_SP_SPECIAL,
    OAPF_SP_XDATA,
    OAPF_SP_CODE,
    OAPF_SP_CODE_FLASH,
    OAPF_SP_ERASE
  } oapf_space_e;
endpackage

// [oapf_core.sv]
// operand addressing and program counter sequencing, with AXI4-Lite regs
// assumes an outside memory model answers o_mem_* with i_mem_rdata/ack
`timescale 1ns/1ns
`include "oapf_defines.svh"
module oapf_core
  import oapf_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output oapf_pkg::oapf_space_e o_mem_space,
  output logic [15:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic        i_mem_ack
);
  import oapf_pkg::*;

  typedef enum logic [1:0] {OAPF_IDLE, OAPF_MEM, OAPF_DONE} oapf_state_e;

  // software-visible state
  logic              code_flash_write_select;
  logic              pointer_select_reg;
  logic              write_protect;
  logic [15:0]       data_pointer0;
  logic [15:0]       data_pointer1;
  logic [7:0]        acc;
  logic [15:0]       pc;
  logic [7:0]        result;
  logic              busy;
  logic              done;
  logic              refused;
  logic              taken;
  logic [7:0]        last_rdata;
  logic [15:0]       last_addr;
  logic [2:0]        last_space;
  logic              last_we;
  // opcode and length latched with the command; operands held from register writes
  logic [3:0]        cmd_op;
  logic [1:0]        cmd_len;
  logic [7:0]        op_byte1;
  logic [7:0]        op_byte2;
  logic [7:0]        index_register_zero;
  logic [7:0]        external_page_high_byte;
  logic              bit_value;
  oapf_state_e       state;

  // write channel capture, taken in either order
  logic              aw_have;
  logic              w_have;
  logic [11:0]       aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] add16(input logic [15:0] a,
                                        input logic [15:0] b);
    return 16'(a + b);
  endfunction

  wire  [15:0] data_pointer_sel = pointer_select_reg ? data_pointer1
                                                     : data_pointer0;
  wire  [15:0] pc_next_seq  = add16(pc, {14'h0000, cmd_len});
  wire  [15:0] rel_disp     = {{8{op_byte2[7]}}, op_byte2};
  wire  [15:0] branch_tgt   = add16(pc_next_seq, rel_disp);
  wire  [15:0] xri_addr     = {external_page_high_byte,
                               index_register_zero};
  wire  [15:0] acc16        = {8'h00, acc};
  wire         dir_is_special = (op_byte1 >= `OAPF_SPECIAL_BASE);
  // strobe-merged images of the operand and pointer words
  wire  [31:0] oper_new = apply_strb({external_page_high_byte,
                                      index_register_zero, op_byte2,
                                      op_byte1}, w_data, w_strb);
  wire  [31:0] ptr0_new = apply_strb({16'h0000, data_pointer0}, w_data,
                                     w_strb);
  wire  [31:0] ptr1_new = apply_strb({16'h0000, data_pointer1}, w_data,
                                     w_strb);
  wire         cf_en        = code_flash_write_select & ~write_protect;
  oapf_op_e    op_e;
  assign op_e = oapf_op_e'(cmd_op);

  // decode of the memory request for the latched command
  logic        need_mem;
  logic        dec_we;
  oapf_space_e dec_space;
  logic [15:0] dec_addr;
  always_comb begin
    need_mem  = 1'b1;
    dec_we    = 1'b0;
    dec_space = OAPF_SP_IRAM;
    dec_addr  = 16'h0000;
    unique case (op_e)
      OAPF_OP_DIR_RD: begin
        dec_space = dir_is_special ? OAPF_SP_SPECIAL
                                   : OAPF_SP_IRAM;
        dec_addr  = {8'h00, op_byte1};
      end
      OAPF_OP_IND_RD: begin
        dec_space = OAPF_SP_IRAM;
        dec_addr  = {8'h00, index_register_zero};
      end
      OAPF_OP_IND_WR: begin
        dec_we    = 1'b1;
        dec_space = OAPF_SP_IRAM;
        dec_addr  = {8'h00, index_register_zero};
      end
      OAPF_OP_XDP_RD: begin
        dec_space = OAPF_SP_XDATA;
        dec_addr  = data_pointer_sel;
      end
      OAPF_OP_XDP_WR: begin
        dec_we    = 1'b1;
        dec_space = cf_en ? OAPF_SP_CODE_FLASH
                          : OAPF_SP_XDATA;
        dec_addr  = data_pointer_sel;
      end
      OAPF_OP_XRI_RD: begin
        dec_space = OAPF_SP_XDATA;
        dec_addr  = xri_addr;
      end
      OAPF_OP_XRI_WR: begin
        dec_we    = 1'b1;
        dec_space = cf_en ? OAPF_SP_CODE_FLASH
                          : OAPF_SP_XDATA;
        dec_addr  = xri_addr;
      end
      OAPF_OP_CODE_DP: begin
        dec_space = OAPF_SP_CODE;
        dec_addr  = add16(data_pointer_sel, acc16);
      end
      OAPF_OP_CODE_PC: begin
        dec_space = OAPF_SP_CODE;
        dec_addr  = add16(pc_next_seq, acc16);
      end
      OAPF_OP_ERASE: begin
        dec_we    = 1'b1;
        dec_space = OAPF_SP_ERASE;
        dec_addr  = data_pointer_sel;
      end
      default: begin
        need_mem  = 1'b0;
      end
    endcase
  end

  // erase only exists behind the write select and outside protection
  wire erase_bad = (op_e == OAPF_OP_ERASE) & ~cf_en;
  wire loads_acc = (op_e == OAPF_OP_DIR_RD) | (op_e == OAPF_OP_IND_RD) |
                   (op_e == OAPF_OP_XDP_RD) | (op_e == OAPF_OP_XRI_RD) |
                   (op_e == OAPF_OP_CODE_DP) | (op_e == OAPF_OP_CODE_PC);
  wire [15:0] next_pc = (op_e == OAPF_OP_BIT_JMP && bit_value) ? branch_tgt
                                                           : pc_next_seq;

  // AXI write path
  wire wr_fire  = aw_have & w_have & ~o_bvalid;
  wire cmd_wr   = wr_fire & (aw_addr == `OAPF_ADDR_CMD);
  wire cmd_ok   = cmd_wr & ~busy & (w_data[1:0] != 2'b00);
  wire wr_known = (aw_addr == `OAPF_ADDR_CTRL) | (aw_addr == `OAPF_ADDR_CMD) |
                  (aw_addr == `OAPF_ADDR_OPER) | (aw_addr == `OAPF_ADDR_PTR0) |
                  (aw_addr == `OAPF_ADDR_PTR1) | (aw_addr == `OAPF_ADDR_ACC) |
                  (aw_addr == `OAPF_ADDR_STATUS);
  assign o_awready = ~aw_have;
  assign o_wready  = ~w_have;
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp  <= `OAPF_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have <= 1'b1;
        aw_addr <= {i_awaddr[11:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_have <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_fire) begin
        aw_have  <= 1'b0;
        w_have   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= (wr_known && !(cmd_wr && busy)) ? `OAPF_RESP_OKAY
                                                   : `OAPF_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; write protect stands in for config bits
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      code_flash_write_select <= 1'b0;
      pointer_select_reg      <= 1'b0;
      write_protect           <= 1'b0;
      data_pointer0           <= 16'h0000;
      data_pointer1           <= 16'h0000;
      external_page_high_byte <= 8'h00;
      index_register_zero     <= 8'h00;
      op_byte1                <= 8'h00;
      op_byte2                <= 8'h00;
      bit_value               <= 1'b0;
    end else if (wr_fire) begin
      if (aw_addr == `OAPF_ADDR_CTRL && w_strb[0]) begin
        code_flash_write_select <= w_data[`OAPF_CTRL_CFWS_BIT];
        pointer_select_reg      <= w_data[`OAPF_CTRL_PSEL_BIT];
        write_protect           <= w_data[`OAPF_CTRL_WPROT_BIT];
        bit_value               <= w_data[`OAPF_CTRL_JBIT_BIT];
      end
      if (aw_addr == `OAPF_ADDR_PTR0) begin
        data_pointer0 <= ptr0_new[15:0];
      end
      if (aw_addr == `OAPF_ADDR_PTR1) begin
        data_pointer1 <= ptr1_new[15:0];
      end
      // operands stay frozen while an instruction is using them
      if (aw_addr == `OAPF_ADDR_OPER && !busy) begin
        {external_page_high_byte, index_register_zero, op_byte2,
         op_byte1} <= oper_new;
      end
    end
  end

  // instruction sequencer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state   <= OAPF_IDLE;
      pc      <= `OAPF_PC_RESET;
      acc     <= 8'h00;
      result  <= 8'h00;
      busy    <= 1'b0;
      done    <= 1'b0;
      refused <= 1'b0;
      taken   <= 1'b0;
      cmd_op  <= 4'h0;
      cmd_len <= 2'd1;
      last_rdata <= 8'h00;
      last_addr  <= 16'h0000;
      last_space <= 3'h0;
      last_we    <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == `OAPF_ADDR_ACC && w_strb[0] && !busy) begin
        acc <= w_data[7:0];
      end
      if (wr_fire && aw_addr == `OAPF_ADDR_STATUS && w_data[0]) begin
        done    <= 1'b0;
        refused <= 1'b0;
      end
      unique case (state)
        OAPF_IDLE: begin
          if (cmd_ok) begin
            cmd_op  <= w_data[`OAPF_OP_W+3:`OAPF_OP_W];
            cmd_len <= w_data[1:0];
            busy    <= 1'b1;
            state   <= OAPF_DONE;
          end
        end
        OAPF_DONE: begin
          if (erase_bad) begin
            refused <= 1'b1;
            taken   <= 1'b0;
            done    <= 1'b1;
            busy    <= 1'b0;
            pc      <= pc_next_seq;
            state   <= OAPF_IDLE;
          end else if (need_mem) begin
            state <= OAPF_MEM;
          end else begin
            if (op_e == OAPF_OP_IMM) begin
              acc    <= op_byte1;
              result <= op_byte1;
            end
            taken <= (op_e == OAPF_OP_BIT_JMP) & bit_value;
            pc    <= next_pc;
            done  <= 1'b1;
            busy  <= 1'b0;
            state <= OAPF_IDLE;
          end
        end
        OAPF_MEM: begin
          if (i_mem_ack) begin
            if (loads_acc) begin
              acc    <= i_mem_rdata;
              result <= i_mem_rdata;
            end
            last_rdata <= i_mem_rdata;
            last_addr  <= dec_addr;
            last_space <= dec_space;
            last_we    <= dec_we;
            taken <= 1'b0;
            pc    <= pc_next_seq;
            done  <= 1'b1;
            busy  <= 1'b0;
            state <= OAPF_IDLE;
          end
        end
      endcase
    end
  end

  assign o_mem_req   = (state == OAPF_MEM);
  assign o_mem_we    = (state == OAPF_MEM) & dec_we;
  assign o_mem_space = dec_space;
  assign o_mem_addr  = dec_addr;
  assign o_mem_wdata = acc;

  // AXI read path
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case ({i_araddr[11:2], 2'b00})
      `OAPF_ADDR_CTRL:   rd_mux = {28'h0, bit_value, write_protect,
                                   pointer_select_reg,
                                   code_flash_write_select};
      `OAPF_ADDR_OPER:   rd_mux = {external_page_high_byte,
                                   index_register_zero, op_byte2, op_byte1};
      `OAPF_ADDR_PTR0:   rd_mux = {16'h0000, data_pointer0};
      `OAPF_ADDR_PTR1:   rd_mux = {16'h0000, data_pointer1};
      `OAPF_ADDR_ACC:    rd_mux = {24'h000000, acc};
      `OAPF_ADDR_PC:     rd_mux = {16'h0000, pc};
      `OAPF_ADDR_RESULT: rd_mux = {24'h000000, result};
      `OAPF_ADDR_STATUS: rd_mux = {28'h0, taken, refused, done, busy};
      `OAPF_ADDR_MEMRD:  rd_mux = {8'h00, last_rdata, last_addr};
      `OAPF_ADDR_MEMWR:  rd_mux = {28'h0, last_we, last_space};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `OAPF_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_hit ? `OAPF_RESP_OKAY : `OAPF_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule

// [oapf_core_sva.sv]
// port-level assertions for oapf_core
// assumes binding into oapf_core; sees only its ports
`timescale 1ns/1ns
module oapf_core_sva
  import oapf_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire logic              i_awvalid,
  input wire logic              o_awready,
  input wire logic              i_wvalid,
  input wire logic              o_wready,
  input wire logic [1:0]        o_bresp,
  input wire logic              o_bvalid,
  input wire logic              i_bready,
  input wire logic              i_arvalid,
  input wire logic              o_arready,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_rvalid,
  input wire logic              i_rready,
  input wire logic              o_mem_req,
  input wire logic              o_mem_we,
  input oapf_pkg::oapf_space_e  o_mem_space,
  input wire logic [15:0]       o_mem_addr,
  input wire logic [7:0]        o_mem_wdata,
  input wire logic              i_mem_ack
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_mem_wait;
    o_mem_req && !i_mem_ack;
  endsequence
  a_write_resp: assert property (s_wr_taken |-> ##2 o_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  a_read_resp: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data missing");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  a_ar_block: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while data pending");
  // access must not wander while the memory has not answered
  a_req_hold: assert property (s_mem_wait |=> o_mem_req
    && $stable(o_mem_addr) && $stable(o_mem_space))
    else $error("memory request changed before ack");
  a_wdata_hold: assert property (s_mem_wait ##0 o_mem_we |=>
    $stable(o_mem_wdata))
    else $error("write byte changed before ack");
  a_special_range: assert property (o_mem_req
    && o_mem_space == OAPF_SP_SPECIAL |-> o_mem_addr[15:7] == 9'h001)
    else $error("register access outside 80..ff");
  a_iram_byte: assert property (o_mem_req
    && o_mem_space == OAPF_SP_IRAM |-> o_mem_addr[15:8] == 8'h00)
    else $error("internal ram address wider than a byte");
  a_code_ro: assert property (o_mem_req
    && o_mem_space == OAPF_SP_CODE |-> !o_mem_we)
    else $error("write to code read space");
  a_erase_we: assert property (o_mem_req
    && o_mem_space == OAPF_SP_ERASE |-> o_mem_we)
    else $error("erase issued as a read");
endmodule
bind oapf_core oapf_core_sva u_sva (.*);

// [oapf_mem_model.sv]
// behavioural memory partner: answers every space 1..4 cycles after the request
// assumes one request at a time, held until acknowledged
`timescale 1ns/1ns
module oapf_mem_model
  import oapf_pkg::*;
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_mem_req,
  input  wire logic             i_mem_we,
  input  oapf_pkg::oapf_space_e i_mem_space,
  input  wire logic [15:0]      i_mem_addr,
  input  wire logic [7:0]       i_mem_wdata,
  output logic [7:0]            o_mem_rdata,
  output logic                  o_mem_ack,
  output oapf_pkg::oapf_space_e o_last_space,
  output logic [15:0]           o_last_addr,
  output logic                  o_last_we,
  output logic [7:0]            o_last_wdata,
  output logic [15:0]           o_n_acc
);
  logic [1:0] wait_cnt;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      o_n_acc <= 16'h0;
      o_mem_rdata <= 8'h5a;
      o_last_space <= OAPF_SP_IRAM;
      o_last_addr <= 16'h0;
      o_last_we <= 1'b0;
      o_last_wdata <= 8'h0;
    end else if (o_mem_ack || !i_mem_req) begin
      // stale data toggles so a late sample never matches by luck
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      wait_cnt <= 2'($urandom % 4);
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
      o_mem_rdata <= ~o_mem_rdata;
    end else begin
      o_mem_ack <= 1'b1;
      o_mem_rdata <= i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ {5'h0, i_mem_space};
      o_last_space <= i_mem_space;
      o_last_addr <= i_mem_addr;
      o_last_we <= i_mem_we;
      o_last_wdata <= i_mem_wdata;
      o_n_acc <= o_n_acc + 16'h1;
    end
  end
endmodule

// [oapf_core_tb_top.sv]
// self-checking bench for oapf_core over AXI4-Lite
// assumes the memory model and the bound checker are compiled first
`timescale 1ns/1ns
`include "oapf_defines.svh"
module oapf_core_tb_top;
  import oapf_pkg::*;
  logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, sel = 0, bt = 0;
  logic [3:0]  strb = 4'hf;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic        awready, wready, bvalid, arready, rvalid, mreq, mwe, mack, lwe;
  logic [1:0]  bresp, rresp, r, ln;
  oapf_space_e msp, lsp;
  logic [15:0] maddr, laddr, nacc, pc_exp, p0, p1, dp;
  logic [7:0]  mwd, mrd, lwd, acc, b1, ix, pg, ds;
  int          errors = 0, n_compared = 0;
  always #25 clk = ~clk;
  oapf_core dut (.i_ref_clk(clk), .i_reset(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(strb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_mem_req(mreq),
    .o_mem_we(mwe), .o_mem_space(msp), .o_mem_addr(maddr),
    .o_mem_wdata(mwd), .i_mem_rdata(mrd), .i_mem_ack(mack));
  oapf_mem_model mem (.i_ref_clk(clk), .i_reset(rst), .i_mem_req(mreq),
    .i_mem_we(mwe), .i_mem_space(msp), .i_mem_addr(maddr),
    .i_mem_wdata(mwd), .o_mem_rdata(mrd), .o_mem_ack(mack),
    .o_last_space(lsp), .o_last_addr(laddr), .o_last_we(lwe),
    .o_last_wdata(lwd), .o_n_acc(nacc));
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang;
    errors++;
    $display("[ERR] wait expected done seen timeout");
    print_verdict;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic pa, pw, pb;
    pb = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int k = 0; k < 50 && !pb; k++) begin
      @(negedge clk);
      pa = awvalid && awready;
      pw = wvalid && wready;
      pb = bvalid;
      r = bresp;
      @(posedge clk);
      if (pa) awvalid <= 0;
      if (pw) wvalid <= 0;
    end
    bready <= 0;
    if (!pb) hang;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    logic pa, pr;
    pr = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int k = 0; k < 50 && !pr; k++) begin
      @(negedge clk);
      pa = arvalid && arready;
      pr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (pa) arvalid <= 0;
    end
    rready <= 0;
    if (!pr) hang;
  endtask
  // one instruction: load acc, issue, poll done, then compare flags, pc, memory access and acc
  task automatic do_op(input oapf_op_e op, input logic mem, rf,
                       input oapf_space_e sp, input logic [15:0] ad,
                       input logic we);
    logic [15:0] n0;
    n0 = nacc;
    axi_wr(`OAPF_ADDR_ACC, {24'h0, acc});
    axi_wr(`OAPF_ADDR_CMD, {24'h0, op, 2'b00, ln});
    check("cmd resp", r, `OAPF_RESP_OKAY);
    d = 0;
    for (int k = 0; k < 40 && !d[1]; k++) axi_rd(`OAPF_ADDR_STATUS);
    if (!d[1]) hang;
    check("refused", d[2], rf);
    check("taken", d[3], op == OAPF_OP_BIT_JMP && bt);
    axi_wr(`OAPF_ADDR_STATUS, 32'h1);
    pc_exp = pc_exp + 16'(ln);
    if (op == OAPF_OP_BIT_JMP && bt) pc_exp = pc_exp + {{8{ds[7]}}, ds};
    axi_rd(`OAPF_ADDR_PC);
    check("pc", d[15:0], pc_exp);
    check("accesses", nacc, n0 + 16'(mem));
    if (mem) begin
      check("space", lsp, sp);
      if (sp != OAPF_SP_ERASE) check("addr", laddr, ad);
      check("write", lwe, we);
      if (we && sp != OAPF_SP_ERASE) check("wdata", lwd, acc);
      if (!we) acc = ad[7:0] ^ ad[15:8] ^ {5'h0, sp};
    end
    if (op == OAPF_OP_IMM) acc = b1;
    axi_rd(`OAPF_ADDR_ACC);
    check("acc", d[7:0], acc);
  endtask
  initial begin
    #(50 * 100000);
    hang;
  end
  initial begin
    void'($urandom(32'h4a352524));
    pc_exp = 0;
    acc = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    axi_rd(`OAPF_ADDR_PC);
    check("pc at reset", d, 32'h0);
    axi_rd(12'h0f0);
    check("unmapped resp", r, `OAPF_RESP_SLVERR);
    axi_wr(`OAPF_ADDR_CMD, 32'h10);
    axi_rd(`OAPF_ADDR_PC);
    check("pc after length 0", d, 32'h0);
    // a partial strobe must leave the other pointer bytes alone
    axi_wr(`OAPF_ADDR_PTR0, 32'h0000_1234);
    strb <= 4'h2;
    axi_wr(`OAPF_ADDR_PTR0, 32'h0000_ab00);
    strb <= 4'hf;
    axi_rd(`OAPF_ADDR_PTR0);
    check("ptr0 strobe", d, 32'h0000_ab34);
    for (int rep = 0; rep < 12; rep++) begin
      b1 = 8'($urandom);
      ix = 8'($urandom);
      pg = 8'($urandom);
      p0 = 16'($urandom);
      p1 = 16'($urandom);
      sel = 1'($urandom);
      bt = 1'($urandom);
      ds = 8'($urandom);
      // widest backward and forward displacements, then a branch not taken
      if (rep == 0) ds = 8'h80;
      if (rep == 1) ds = 8'h7f;
      if (rep < 2) bt = 1'b1;
      if (rep == 2) bt = 1'b0;
      ln = 2'(1 + $urandom % 3);
      // boundary of the direct split, and the serial port register address
      if (rep == 0) b1 = 8'h7f;
      if (rep == 0) ix = 8'h99;
      if (rep == 1) b1 = 8'h80;
      dp = sel ? p1 : p0;
      axi_wr(`OAPF_ADDR_OPER, {pg, ix, ds, b1});
      axi_wr(`OAPF_ADDR_PTR0, {16'h0, p0});
      axi_wr(`OAPF_ADDR_PTR1, {16'h0, p1});
      axi_wr(`OAPF_ADDR_CTRL, {28'h0, bt, 1'b0, sel, 1'b0});
      do_op(OAPF_OP_IMM, 0, 0, OAPF_SP_IRAM, 0, 0);
      do_op(OAPF_OP_BIT_JMP, 0, 0, OAPF_SP_IRAM, 0, 0);
      do_op(OAPF_OP_NOP, 0, 0, OAPF_SP_IRAM, 0, 0);
      do_op(OAPF_OP_DIR_RD, 1, 0, b1[7] ? OAPF_SP_SPECIAL : OAPF_SP_IRAM,
            {8'h0, b1}, 0);
      do_op(OAPF_OP_IND_RD, 1, 0, OAPF_SP_IRAM, {8'h0, ix}, 0);
      do_op(OAPF_OP_IND_WR, 1, 0, OAPF_SP_IRAM, {8'h0, ix}, 1);
      do_op(OAPF_OP_XDP_RD, 1, 0, OAPF_SP_XDATA, dp, 0);
      do_op(OAPF_OP_XDP_WR, 1, 0, OAPF_SP_XDATA, dp, 1);
      do_op(OAPF_OP_XRI_RD, 1, 0, OAPF_SP_XDATA, {pg, ix}, 0);
      do_op(OAPF_OP_XRI_WR, 1, 0, OAPF_SP_XDATA, {pg, ix}, 1);
      do_op(OAPF_OP_CODE_DP, 1, 0, OAPF_SP_CODE, dp + 16'(acc), 0);
      do_op(OAPF_OP_CODE_PC, 1, 0, OAPF_SP_CODE,
            pc_exp + 16'(ln) + 16'(acc), 0);
      do_op(OAPF_OP_ERASE, 0, 1, OAPF_SP_IRAM, 0, 0);
      axi_wr(`OAPF_ADDR_CTRL, {30'h0, sel, 1'b1});
      do_op(OAPF_OP_XDP_WR, 1, 0, OAPF_SP_CODE_FLASH, dp, 1);
      do_op(OAPF_OP_ERASE, 1, 0, OAPF_SP_ERASE, dp, 1);
      axi_wr(`OAPF_ADDR_CTRL, {29'h0, 1'b1, sel, 1'b1});
      do_op(OAPF_OP_ERASE, 0, 1, OAPF_SP_IRAM, 0, 0);
    end
    print_verdict;
  end
endmodule
